// [sfd_pkg.sv]
// Constants and types shared by the serial flash command decoder
package sfd_pkg;

	// Instruction codes
	localparam logic [7:0] SFD_OP_WRSR     = 8'h01;
	localparam logic [7:0] SFD_OP_PROG     = 8'h02;
	localparam logic [7:0] SFD_OP_READ     = 8'h03;
	localparam logic [7:0] SFD_OP_WRDIS    = 8'h04;
	localparam logic [7:0] SFD_OP_RDSR1    = 8'h05;
	localparam logic [7:0] SFD_OP_WREN     = 8'h06;
	localparam logic [7:0] SFD_OP_FAST     = 8'h0b;
	localparam logic [7:0] SFD_OP_SECTOR   = 8'h20;
	localparam logic [7:0] SFD_OP_RDSR3    = 8'h33;
	localparam logic [7:0] SFD_OP_RDSR2    = 8'h35;
	localparam logic [7:0] SFD_OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] SFD_OP_SEC_PROG = 8'h42;
	localparam logic [7:0] SFD_OP_SEC_ERAS = 8'h44;
	localparam logic [7:0] SFD_OP_SEC_READ = 8'h48;
	localparam logic [7:0] SFD_OP_VOL_WREN = 8'h50;
	localparam logic [7:0] SFD_OP_PARAM    = 8'h5a;
	localparam logic [7:0] SFD_OP_CHIP_A   = 8'h60;
	localparam logic [7:0] SFD_OP_RST_EN   = 8'h66;
	localparam logic [7:0] SFD_OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] SFD_OP_SUSPEND  = 8'h75;
	localparam logic [7:0] SFD_OP_WRAP     = 8'h77;
	localparam logic [7:0] SFD_OP_RESUME   = 8'h7a;
	localparam logic [7:0] SFD_OP_LEG_ID   = 8'h90;
	localparam logic [7:0] SFD_OP_RESET    = 8'h99;
	localparam logic [7:0] SFD_OP_JEDEC_ID = 8'h9f;
	localparam logic [7:0] SFD_OP_RELEASE  = 8'hab;
	localparam logic [7:0] SFD_OP_PWR_DOWN = 8'hb9;
	localparam logic [7:0] SFD_OP_DUAL_IO  = 8'hbb;
	localparam logic [7:0] SFD_OP_CHIP_B   = 8'hc7;
	localparam logic [7:0] SFD_OP_BLOCK    = 8'hd8;
	localparam logic [7:0] SFD_OP_QUAD_IO  = 8'heb;

	// Phase lengths and in-byte clock positions in link clocks
	localparam logic [5:0] SFD_ADDR_SINGLE = 6'h18;
	localparam logic [5:0] SFD_ADDR_DUAL   = 6'h0c;
	localparam logic [5:0] SFD_ADDR_QUAD   = 6'h06;
	localparam logic [3:0] SFD_MODE_DUAL   = 4'h4;
	localparam logic [3:0] SFD_MODE_QUAD   = 4'h2;
	localparam logic [4:0] SFD_DUMMY_BYTE  = 5'h08;
	localparam logic [4:0] SFD_DUMMY_QUAD  = 5'h04;
	localparam logic [4:0] SFD_DUMMY_RES   = 5'h18;
	localparam logic [2:0] SFD_WRAP_CLK    = 3'h6;
	localparam logic [2:0] SFD_BYTE_LAST   = 3'h7;

	// Continuous read mode bits pattern and security register fields
	localparam logic [1:0] SFD_CONT_PATTERN = 2'h2;
	localparam logic [7:0] SFD_SEC_HIGH     = 8'h00;
	localparam logic [3:0] SFD_SEC_LOW_NIB  = 4'h0;
	localparam logic [1:0] SFD_SEC_LOCKED   = 2'h0;
	localparam logic [7:0] SFD_IDLE_BYTE    = 8'hff;

	// Lane widths
	localparam logic [1:0] SFD_W1 = 2'h0;
	localparam logic [1:0] SFD_W2 = 2'h1;
	localparam logic [1:0] SFD_W4 = 2'h2;

	typedef enum logic [2:0] {
		SFD_SRC_SR1,
		SFD_SRC_SR2,
		SFD_SRC_SR3,
		SFD_SRC_DEVID,
		SFD_SRC_LEGACY,
		SFD_SRC_JEDEC,
		SFD_SRC_ARRAY
	} sfd_src_type;

	typedef enum logic [2:0] {
		SFD_ST_IDLE,
		SFD_ST_OPCODE,
		SFD_ST_ADDR,
		SFD_ST_MODE,
		SFD_ST_DUMMY,
		SFD_ST_DIN,
		SFD_ST_DOUT,
		SFD_ST_SKIP
	} sfd_phase_type;

	typedef struct packed {
		logic        known;
		logic        rd;
		logic        wr;
		logic        din;
		logic        quad;
		logic [1:0]  iw;
		logic [1:0]  ow;
		logic [5:0]  aclk;
		logic [3:0]  mclk;
		logic [4:0]  dclk;
		sfd_src_type src;
	} sfd_cmd_type;

endpackage

// [sfd_decoder.sv]
// Serial flash command decoder: link sampling, framing, decode, data shifting
`timescale 1ns/1ps

module sfd_decoder #(
	parameter logic [7:0] MFR_ID   = 8'h5a, // Arbitrary identity value
	parameter logic [7:0] DEV_ID   = 8'h3c, // Arbitrary identity value
	parameter logic [7:0] MEM_TYPE = 8'h24, // Arbitrary identity value
	parameter logic [7:0] CAPACITY = 8'h12  // Arbitrary identity value
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_cs_n,
	input  wire logic        i_sck,
	input  wire logic [3:0]  i_lane_in,
	output logic [3:0]       o_lane_out,
	output logic [3:0]       o_lane_oe_n,
	input  wire logic [7:0]  i_status_reg_first,
	input  wire logic [7:0]  i_status_reg_second,
	input  wire logic [7:0]  i_status_reg_third,
	input  wire logic        i_quad_enable_bit,
	input  wire logic        i_array_busy,
	input  wire logic        i_status_write_busy,
	input  wire logic        i_op_done,
	input  wire logic        i_rd_valid,
	input  wire logic [7:0]  i_rd_data,
	output logic             o_rd_ready,
	output logic             o_cmd_strobe,
	output logic [7:0]       o_cmd_opcode,
	output logic [23:0]      o_cmd_addr,
	output logic             o_cmd_volatile,
	output logic [1:0]       o_sec_index,
	output logic             o_wr_strobe,
	output logic [7:0]       o_wr_data,
	output logic             o_write_enable_latch,
	output logic             o_deep_power_down,
	output logic             o_cont_mode,
	output logic             o_soft_reset,
	output logic [2:0]       o_wrap_bits
);
	import sfd_pkg::*;

	typedef struct packed {
		logic            cs_s1;
		logic            cs_s2;
		logic            cs_d;
		logic            sck_s1;
		logic            sck_s2;
		logic            sck_d;
		logic [3:0]      ln_s1;
		logic [3:0]      ln_s2;
		sfd_phase_type   st;
		sfd_cmd_type     info;
		logic [7:0]      op;
		logic [5:0]      ph_cnt;
		logic [2:0]      bit_tot;
		logic [7:0]      shreg;
		logic [23:0]     addr;
		logic [7:0]      mode;
		logic [7:0]      out_byte;
		logic [2:0]      out_left;
		logic [1:0]      out_idx;
		logic            drive;
		logic            write_enable_latch;
		logic            vol_arm;
		logic            rst_arm;
		logic            dpd;
		logic            cont;
		logic [2:0]      wrap;
		logic [1:0][7:0] fmem;
		logic            f_wr;
		logic            f_rd;
		logic [1:0]      f_cnt;
		logic            cmd_stb;
		logic [7:0]      cmd_op;
		logic [23:0]     cmd_addr;
		logic            cmd_vol;
		logic            wr_stb;
		logic [7:0]      wr_data;
		logic            soft_rst;
	} sfd_state_type;

	sfd_state_type s;
	sfd_state_type next_s;

	function automatic sfd_cmd_type decode(input logic [7:0] op);
		sfd_cmd_type c;
		c = '0;
		c.known = 1'b1;
		c.src = SFD_SRC_ARRAY;
		case (op)
			SFD_OP_RDSR1: begin
				c.rd = 1'b1;
				c.src = SFD_SRC_SR1;
			end
			SFD_OP_RDSR2: begin
				c.rd = 1'b1;
				c.src = SFD_SRC_SR2;
			end
			SFD_OP_RDSR3: begin
				c.rd = 1'b1;
				c.src = SFD_SRC_SR3;
			end
			SFD_OP_WREN, SFD_OP_VOL_WREN, SFD_OP_WRDIS, SFD_OP_SUSPEND,
			SFD_OP_RESUME, SFD_OP_RST_EN, SFD_OP_RESET,
			SFD_OP_PWR_DOWN: begin
				c.din = 1'b0;
			end
			SFD_OP_CHIP_A, SFD_OP_CHIP_B: begin
				c.wr = 1'b1;
			end
			SFD_OP_WRSR: begin
				c.wr = 1'b1;
				c.din = 1'b1;
			end
			SFD_OP_PROG, SFD_OP_SEC_PROG: begin
				c.wr = 1'b1;
				c.din = 1'b1;
				c.aclk = SFD_ADDR_SINGLE;
			end
			SFD_OP_SECTOR, SFD_OP_BLOCK, SFD_OP_SEC_ERAS: begin
				c.wr = 1'b1;
				c.aclk = SFD_ADDR_SINGLE;
			end
			SFD_OP_WRAP: begin
				c.aclk = SFD_ADDR_SINGLE;
			end
			SFD_OP_READ: begin
				c.rd = 1'b1;
				c.aclk = SFD_ADDR_SINGLE;
			end
			SFD_OP_FAST, SFD_OP_PARAM, SFD_OP_SEC_READ: begin
				c.rd = 1'b1;
				c.aclk = SFD_ADDR_SINGLE;
				c.dclk = SFD_DUMMY_BYTE;
			end
			SFD_OP_DUAL_OUT: begin
				c.rd = 1'b1;
				c.aclk = SFD_ADDR_SINGLE;
				c.dclk = SFD_DUMMY_BYTE;
				c.ow = SFD_W2;
			end
			SFD_OP_QUAD_OUT: begin
				c.rd = 1'b1;
				c.quad = 1'b1;
				c.aclk = SFD_ADDR_SINGLE;
				c.dclk = SFD_DUMMY_BYTE;
				c.ow = SFD_W4;
			end
			SFD_OP_DUAL_IO: begin
				c.rd = 1'b1;
				c.iw = SFD_W2;
				c.ow = SFD_W2;
				c.aclk = SFD_ADDR_DUAL;
				c.mclk = SFD_MODE_DUAL;
			end
			SFD_OP_QUAD_IO: begin
				c.rd = 1'b1;
				c.quad = 1'b1;
				c.iw = SFD_W4;
				c.ow = SFD_W4;
				c.aclk = SFD_ADDR_QUAD;
				c.mclk = SFD_MODE_QUAD;
				c.dclk = SFD_DUMMY_QUAD;
			end
			SFD_OP_RELEASE: begin
				c.rd = 1'b1;
				c.dclk = SFD_DUMMY_RES;
				c.src = SFD_SRC_DEVID;
			end
			SFD_OP_LEG_ID: begin
				c.rd = 1'b1;
				c.aclk = SFD_ADDR_SINGLE;
				c.src = SFD_SRC_LEGACY;
			end
			SFD_OP_JEDEC_ID: begin
				c.rd = 1'b1;
				c.src = SFD_SRC_JEDEC;
			end
			default: begin
				c.known = 1'b0;
			end
		endcase
		return c;
	endfunction

	// Even bits on lane zero, odd bits on lane one; lane three tops a nibble
	function automatic logic [7:0] shift8(input logic [7:0] b,
		input logic [3:0] ln, input logic [1:0] w);
		case (w)
			SFD_W1: shift8 = {b[6:0], ln[0]};
			SFD_W2: shift8 = {b[5:0], ln[1], ln[0]};
			default: shift8 = {b[3:0], ln};
		endcase
	endfunction

	function automatic logic [23:0] shift24(input logic [23:0] a,
		input logic [3:0] ln, input logic [1:0] w);
		case (w)
			SFD_W1: shift24 = {a[22:0], ln[0]};
			SFD_W2: shift24 = {a[21:0], ln[1], ln[0]};
			default: shift24 = {a[19:0], ln};
		endcase
	endfunction

	// Clocks left after the first one of a byte at the given lane width
	function automatic logic [2:0] byte_steps(input logic [1:0] w);
		case (w)
			SFD_W1: byte_steps = 3'h7;
			SFD_W2: byte_steps = 3'h3;
			default: byte_steps = 3'h1;
		endcase
	endfunction

	function automatic logic sec_ok(input logic [23:0] a);
		sec_ok = a[23:16] == SFD_SEC_HIGH && a[11:8] == SFD_SEC_LOW_NIB &&
			a[15:14] == 2'h0;
	endfunction

	logic        sck_rise;
	logic        sck_fall;
	logic        cs_rise;
	logic        cs_fall;
	logic        accept;
	logic        aligned;
	logic        push;
	logic [7:0]  op_now;
	logic [7:0]  src_byte;
	sfd_cmd_type dec;

	always_comb begin
		next_s = s;
		next_s.cmd_stb = 1'b0;
		next_s.wr_stb = 1'b0;
		next_s.soft_rst = 1'b0;
		next_s.cs_s1 = i_cs_n;
		next_s.cs_s2 = s.cs_s1;
		next_s.cs_d = s.cs_s2;
		next_s.sck_s1 = i_sck;
		next_s.sck_s2 = s.sck_s1;
		next_s.sck_d = s.sck_s2;
		next_s.ln_s1 = i_lane_in;
		next_s.ln_s2 = s.ln_s1;
		sck_rise = s.sck_s2 & ~s.sck_d & ~s.cs_s2;
		sck_fall = ~s.sck_s2 & s.sck_d & ~s.cs_s2;
		cs_rise = s.cs_s2 & ~s.cs_d;
		cs_fall = ~s.cs_s2 & s.cs_d;
		op_now = shift8(s.shreg, s.ln_s2, SFD_W1);
		dec = decode(op_now);
		accept = dec.known && (!s.dpd || op_now == SFD_OP_RELEASE) &&
			(!dec.quad || i_quad_enable_bit);
		if (i_array_busy && !(dec.src inside {SFD_SRC_SR1, SFD_SRC_SR2,
			SFD_SRC_SR3} && dec.rd) && op_now != SFD_OP_SUSPEND)
			accept = 1'b0;
		if (i_status_write_busy && !(dec.rd && dec.src inside
			{SFD_SRC_SR1, SFD_SRC_SR2, SFD_SRC_SR3}))
			accept = 1'b0;
		// A program, erase or status write counts only on a byte edge
		aligned = s.st == SFD_ST_DIN && s.bit_tot == 3'h0;

		// Read data buffer: the drain side stalls the array source
		push = i_rd_valid && s.f_cnt != 2'h2;
		case (s.info.src)
			SFD_SRC_SR1: src_byte = i_status_reg_first;
			SFD_SRC_SR2: src_byte = i_status_reg_second;
			SFD_SRC_SR3: src_byte = i_status_reg_third;
			SFD_SRC_DEVID: src_byte = DEV_ID;
			SFD_SRC_LEGACY: src_byte = (s.out_idx[0] ^ s.addr[0]) ?
				DEV_ID : MFR_ID;
			SFD_SRC_JEDEC: src_byte = s.out_idx == 2'h0 ? MFR_ID :
				(s.out_idx == 2'h1 ? MEM_TYPE : CAPACITY);
			default: src_byte = s.f_cnt != 2'h0 ? s.fmem[s.f_rd] :
				SFD_IDLE_BYTE;
		endcase

		// Set wins over the done clear because the commit below runs later
		if (i_op_done)
			next_s.write_enable_latch = 1'b0;

		if (cs_fall) begin
			next_s.bit_tot = 3'h0;
			next_s.ph_cnt = 6'h0;
			next_s.out_left = 3'h0;
			next_s.out_idx = 2'h0;
			next_s.st = s.cont ? SFD_ST_ADDR : SFD_ST_OPCODE;
		end else if (sck_rise) begin
			next_s.bit_tot = s.bit_tot + 3'h1;
			next_s.ph_cnt = s.ph_cnt + 6'h1;
			case (s.st)
				SFD_ST_OPCODE: begin
					next_s.shreg = op_now;
					if (s.ph_cnt[2:0] == SFD_BYTE_LAST) begin
						next_s.op = op_now;
						next_s.info = dec;
						next_s.ph_cnt = 6'h0;
						next_s.addr = '0;
						if (!accept)
							next_s.st = SFD_ST_SKIP;
						else if (dec.aclk != 6'h0)
							next_s.st = SFD_ST_ADDR;
						else if (dec.dclk != 5'h0)
							next_s.st = SFD_ST_DUMMY;
						else if (dec.rd)
							next_s.st = SFD_ST_DOUT;
						else
							next_s.st = SFD_ST_DIN;
						if (accept && op_now == SFD_OP_RELEASE)
							next_s.dpd = 1'b0;
						if (accept && dec.rd && dec.aclk == 6'h0) begin
							next_s.cmd_stb = 1'b1;
							next_s.cmd_op = op_now;
						end
					end
				end
				SFD_ST_ADDR: begin
					next_s.addr = shift24(s.addr, s.ln_s2, s.info.iw);
					if (s.ph_cnt == s.info.aclk - 6'h1) begin
						next_s.ph_cnt = 6'h0;
						if (s.info.mclk != 4'h0)
							next_s.st = SFD_ST_MODE;
						else if (s.info.dclk != 5'h0)
							next_s.st = SFD_ST_DUMMY;
						else if (s.info.rd)
							next_s.st = SFD_ST_DOUT;
						else
							next_s.st = SFD_ST_DIN;
						if (s.info.rd && s.info.mclk == 4'h0) begin
							next_s.cmd_stb = 1'b1;
							next_s.cmd_op = s.op;
							next_s.cmd_addr = next_s.addr;
						end
					end
				end
				SFD_ST_MODE: begin
					next_s.mode = shift8(s.mode, s.ln_s2, s.info.iw);
					if (s.ph_cnt[3:0] == s.info.mclk - 4'h1) begin
						next_s.ph_cnt = 6'h0;
						next_s.st = s.info.dclk != 5'h0 ? SFD_ST_DUMMY :
							SFD_ST_DOUT;
						// Mode pattern keeps the next frame opcode-free
						next_s.cont = next_s.mode[5:4] == SFD_CONT_PATTERN;
						next_s.cmd_stb = 1'b1;
						next_s.cmd_op = s.op;
						next_s.cmd_addr = s.addr;
					end
				end
				SFD_ST_DUMMY: begin
					if (s.ph_cnt[4:0] == s.info.dclk - 5'h1) begin
						next_s.ph_cnt = 6'h0;
						next_s.st = SFD_ST_DOUT;
					end
				end
				SFD_ST_DIN: begin
					next_s.shreg = shift8(s.shreg, s.ln_s2, SFD_W1);
					if (s.op == SFD_OP_WRAP && s.ph_cnt[2:0] == SFD_WRAP_CLK)
						next_s.wrap = s.ln_s2[2:0];
					if (s.ph_cnt[2:0] == SFD_BYTE_LAST) begin
						next_s.ph_cnt = 6'h0;
						next_s.wr_stb = s.info.din;
						next_s.wr_data = next_s.shreg;
					end
				end
				default: begin
					next_s.ph_cnt = 6'h0;
				end
			endcase
		end else if (sck_fall && s.st == SFD_ST_DOUT) begin
			// Output changes on the falling edge; host samples on rising
			next_s.drive = 1'b1;
			if (s.out_left == 3'h0) begin
				next_s.out_byte = src_byte;
				next_s.out_left = byte_steps(s.info.ow);
				next_s.out_idx = s.out_idx == 2'h2 ? 2'h0 :
					s.out_idx + 2'h1;
				if (s.info.src == SFD_SRC_ARRAY && s.f_cnt != 2'h0) begin
					next_s.f_rd = ~s.f_rd;
					next_s.f_cnt = s.f_cnt - 2'h1;
				end
			end else begin
				next_s.out_left = s.out_left - 3'h1;
				case (s.info.ow)
					SFD_W1: next_s.out_byte = {s.out_byte[6:0], 1'b0};
					SFD_W2: next_s.out_byte = {s.out_byte[5:0], 2'h0};
					default: next_s.out_byte = {s.out_byte[3:0], 4'h0};
				endcase
			end
		end

		if (push && !cs_rise) begin
			next_s.fmem[s.f_wr] = i_rd_data;
			next_s.f_wr = ~s.f_wr;
			next_s.f_cnt = next_s.f_cnt + 2'h1;
		end

		if (cs_rise) begin
			next_s.st = SFD_ST_IDLE;
			next_s.drive = 1'b0;
			next_s.f_cnt = 2'h0;
			next_s.f_rd = 1'b0;
			next_s.f_wr = 1'b0;
			if (s.st != SFD_ST_IDLE && s.st != SFD_ST_OPCODE &&
				s.st != SFD_ST_SKIP && !s.info.rd) begin
				next_s.vol_arm = 1'b0;
				next_s.rst_arm = 1'b0;
			end
			if (aligned) begin
				case (s.op)
					SFD_OP_WREN: next_s.write_enable_latch = 1'b1;
					SFD_OP_WRDIS: next_s.write_enable_latch = 1'b0;
					SFD_OP_VOL_WREN: next_s.vol_arm = 1'b1;
					SFD_OP_RST_EN: next_s.rst_arm = 1'b1;
					SFD_OP_PWR_DOWN: next_s.dpd = 1'b1;
					SFD_OP_RESET: begin
						if (s.rst_arm) begin
							next_s.soft_rst = 1'b1;
							next_s.write_enable_latch = 1'b0;
							next_s.vol_arm = 1'b0;
							next_s.cont = 1'b0;
							next_s.wrap = 3'h0;
						end
					end
					default: begin
					end
				endcase
				if (!s.info.wr || s.write_enable_latch ||
					(s.op == SFD_OP_WRSR && s.vol_arm)) begin
					if (!(s.op inside {SFD_OP_SEC_PROG, SFD_OP_SEC_ERAS}) ||
						(sec_ok(s.addr) &&
						s.addr[13:12] != SFD_SEC_LOCKED)) begin
						next_s.cmd_stb = 1'b1;
						next_s.cmd_op = s.op;
						next_s.cmd_addr = s.addr;
						next_s.cmd_vol = s.op == SFD_OP_WRSR && !s.write_enable_latch &&
							s.vol_arm;
					end
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			s <= {3'b111, {($bits(s) - 3){1'b0}}};
		else
			s <= next_s;
	end

	// Lanes are driven only during the data-out phase of an accepted read
	always_comb begin
		o_lane_out = 4'h0;
		o_lane_oe_n = 4'hf;
		if (s.drive && s.st == SFD_ST_DOUT) begin
			case (s.info.ow)
				SFD_W1: begin
					o_lane_out[1] = s.out_byte[7];
					o_lane_oe_n = 4'hd;
				end
				SFD_W2: begin
					o_lane_out[1:0] = s.out_byte[7:6];
					o_lane_oe_n = 4'hc;
				end
				default: begin
					o_lane_out = s.out_byte[7:4];
					o_lane_oe_n = 4'h0;
				end
			endcase
		end
	end

	assign o_rd_ready = s.f_cnt != 2'h2;
	assign o_cmd_strobe = s.cmd_stb;
	assign o_cmd_opcode = s.cmd_op;
	assign o_cmd_addr = s.cmd_addr;
	assign o_cmd_volatile = s.cmd_vol;
	assign o_sec_index = s.cmd_addr[13:12];
	assign o_wr_strobe = s.wr_stb;
	assign o_wr_data = s.wr_data;
	assign o_write_enable_latch = s.write_enable_latch;
	assign o_deep_power_down = s.dpd;
	assign o_cont_mode = s.cont;
	assign o_soft_reset = s.soft_rst;
	assign o_wrap_bits = s.wrap;

endmodule

// [sfd_decoder_sva.sv]
// Port assertions for the flash command decoder
`timescale 1ns/1ps
module sfd_chk
	import sfd_pkg::*;
(
	input wire logic       i_sys_clk,
	input wire logic       i_sys_rst,
	input wire logic       i_cs_n,
	input wire logic       i_array_busy,
	input wire logic       i_status_write_busy,
	input wire logic       i_op_done,
	input wire logic [3:0] o_lane_oe_n,
	input wire logic       o_cmd_strobe,
	input wire logic [7:0] o_cmd_opcode,
	input wire logic       o_write_enable_latch,
	input wire logic       o_deep_power_down
);
	logic wren;
	logic stat;
	logic wrop;
	assign wren = o_cmd_strobe && o_cmd_opcode == SFD_OP_WREN;
	assign stat = o_cmd_opcode inside {SFD_OP_RDSR1, SFD_OP_RDSR2, SFD_OP_RDSR3};
	assign wrop = o_cmd_opcode inside {SFD_OP_PROG, SFD_OP_SECTOR, SFD_OP_BLOCK,
		SFD_OP_CHIP_A, SFD_OP_CHIP_B};
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	a_lanes_idle: assert property (
		i_cs_n [*6] |-> o_lane_oe_n == 4'hf)
		else $error("lanes driven while deselected");
	a_wel_set: assert property (
		wren |-> o_write_enable_latch)
		else $error("latch not set by write enable");
	a_wel_rise: assert property (
		$rose(o_write_enable_latch) |-> wren)
		else $error("latch set by another command");
	a_wel_clear: assert property (
		i_op_done |=> !o_write_enable_latch || wren)
		else $error("latch kept after completion");
	a_write_gate: assert property (
		o_cmd_strobe && wrop |-> $past(o_write_enable_latch))
		else $error("write taken without latch");
	a_busy_gate: assert property (
		o_cmd_strobe && i_array_busy && $past(i_array_busy, 8)
		|-> stat || o_cmd_opcode == SFD_OP_SUSPEND)
		else $error("command taken while array busy");
	a_sw_gate: assert property (
		o_cmd_strobe && i_status_write_busy && $past(i_status_write_busy, 8)
		|-> stat)
		else $error("command taken during status write");
	a_pd_only: assert property (
		o_cmd_strobe && $past(o_deep_power_down)
		|-> o_cmd_opcode == SFD_OP_RELEASE)
		else $error("command taken in power down");

	c_prog: cover property (o_cmd_strobe && o_cmd_opcode == SFD_OP_PROG);
	c_read: cover property (o_cmd_strobe && o_cmd_opcode == SFD_OP_READ);
	c_pd: cover property ($rose(o_deep_power_down));
endmodule

bind sfd_decoder sfd_chk u_chk (.i_sys_clk, .i_sys_rst, .i_cs_n, .i_array_busy,
	.i_status_write_busy, .i_op_done, .o_lane_oe_n, .o_cmd_strobe,
	.o_cmd_opcode, .o_write_enable_latch, .o_deep_power_down);

// [sfd_host_model.sv]
// Host side of the link: chip select, link clock and input lanes
`timescale 1ns/1ps
module sfd_host_model (
	output logic            o_cs_n,
	output logic            o_sck,
	output logic [3:0]      o_lane,
	input  wire logic [3:0] i_lane
);
	logic [7:0] rx = 8'h00;
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_lane = 4'h0;
	end
	// Clock stands low between frames; spare lanes toggle so none look held
	task automatic xfer(input logic [7:0] tx, input int nbit);
		for (int k = 7; k > 7 - nbit; k--) begin
			o_lane = {~o_lane[3:1], tx[k]};
			#24 o_sck = 1'b1;
			rx = {rx[6:0], i_lane[1]};
			#24 o_sck = 1'b0;
		end
	endtask
	// One clock with all four lanes driven, for multi-lane phases
	task automatic xfer4(input logic [3:0] tx);
		o_lane = tx;
		#24 o_sck = 1'b1;
		#24 o_sck = 1'b0;
	endtask
	task automatic open_f();
		o_cs_n = 1'b0;
		#24;
	endtask
	// Any bit count may precede the rise, so loose endings are possible
	task automatic close_f();
		#24 o_cs_n = 1'b1;
		#48;
	endtask
endmodule

// [tb.sv]
// Self-checking bench for the flash command decoder
`timescale 1ns/1ps
module tb;
	import sfd_pkg::*;
	logic        i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_op_done = 1'b0;
	logic        i_array_busy = 1'b0, i_status_write_busy = 1'b0;
	logic        i_quad_enable_bit = 1'b0, i_rd_valid = 1'b0;
	logic [7:0]  i_status_reg_first = 8'h00, i_status_reg_second = 8'h00;
	logic [7:0]  i_status_reg_third = 8'h00, wdat;
	logic [31:0] seed = 32'hb65e, r;
	logic [7:0]  ers [4] = '{SFD_OP_SECTOR, SFD_OP_BLOCK, SFD_OP_CHIP_B,
		SFD_OP_CHIP_A};
	logic [7:0]  sro [3] = '{SFD_OP_RDSR1, SFD_OP_RDSR2, SFD_OP_RDSR3};
	wire         i_cs_n, i_sck, o_rd_ready, o_cmd_strobe, o_cmd_volatile;
	wire         o_wr_strobe, o_write_enable_latch, o_deep_power_down;
	wire         o_cont_mode, o_soft_reset;
	wire [3:0]   i_lane_in, o_lane_out, o_lane_oe_n, h_lane;
	wire [7:0]   i_rd_data, o_cmd_opcode, o_wr_data;
	wire [23:0]  o_cmd_addr;
	wire [1:0]   o_sec_index;
	wire [2:0]   o_wrap_bits;
	int          err_total, checked, n_cmd, n_rst, fed, k;

	always #2 i_sys_clk = ~i_sys_clk;
	assign i_lane_in = (o_lane_oe_n & h_lane) | (~o_lane_oe_n & o_lane_out);
	assign i_rd_data = dat(fed);
	// Device code is an arbitrary value
	sfd_decoder #(.DEV_ID(8'hc3)) dut (.i_sys_clk, .i_sys_rst, .i_cs_n,
		.i_sck, .i_lane_in, .o_lane_out, .o_lane_oe_n, .i_status_reg_first,
		.i_status_reg_second, .i_status_reg_third, .i_quad_enable_bit,
		.i_array_busy, .i_status_write_busy, .i_op_done, .i_rd_valid,
		.i_rd_data, .o_rd_ready, .o_cmd_strobe, .o_cmd_opcode, .o_cmd_addr,
		.o_cmd_volatile, .o_sec_index, .o_wr_strobe, .o_wr_data,
		.o_write_enable_latch, .o_deep_power_down, .o_cont_mode,
		.o_soft_reset, .o_wrap_bits);
	sfd_host_model host (.o_cs_n(i_cs_n), .o_sck(i_sck), .o_lane(h_lane),
		.i_lane(i_lane_in));

	always @(posedge i_sys_clk) begin
		n_cmd += o_cmd_strobe;
		n_rst += o_soft_reset;
		if (o_wr_strobe)
			wdat = o_wr_data;
		if (i_rd_valid && o_rd_ready)
			fed <= fed + 1;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] dat(input int n);
		return 8'h47 + 8'(n * 29);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick();
		@(posedge i_sys_clk);
		#1;
	endtask
	task automatic hdr(input logic [63:0] w, input int nb);
		tick();
		host.open_f();
		for (int i = 0; i < nb; i++)
			host.xfer(w[63-8*i -: 8], 8);
	endtask
	task automatic frame(input logic [63:0] w, input int nb, input int tail);
		hdr(w, nb);
		if (tail > 0)
			host.xfer(8'h00, tail);
		host.close_f();
	endtask
	task automatic op1(input logic [7:0] op);
		frame({op, 56'h0}, 1, 0);
	endtask
	task automatic get(input logic [7:0] exp);
		host.xfer(8'h00, 8);
		chk(host.rx, exp);
	endtask
	task automatic done();
		tick();
		i_op_done = 1'b1;
		tick();
		i_op_done = 1'b0;
		tick();
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge i_sys_clk);
		#1 i_sys_rst = 1'b0;
		repeat (3) tick();
		chk(o_lane_oe_n, 4'hf);
		chk(o_write_enable_latch, 1'b0);
		chk(o_rd_ready, 1'b1);
		op1(SFD_OP_WREN);
		chk(o_write_enable_latch, 1'b1);
		op1(SFD_OP_VOL_WREN);
		chk(o_cmd_opcode, SFD_OP_VOL_WREN);
		chk(o_write_enable_latch, 1'b1);
		r = rnd();
		frame({SFD_OP_PROG, r, 24'h0}, 5, 0);
		chk(o_cmd_addr, r[31:8]);
		chk(wdat, r[7:0]);
		done();
		chk(o_write_enable_latch, 1'b0);
		foreach (ers[i]) begin
			r = rnd();
			op1(SFD_OP_WREN);
			k = n_cmd;
			frame({ers[i], r[23:0], 32'h0}, i < 2 ? 4 : 1, 3);
			chk(n_cmd, k);
			frame({ers[i], r[23:0], 32'h0}, i < 2 ? 4 : 1, 0);
			chk(n_cmd, k + 1);
			chk(o_cmd_opcode, ers[i]);
			done();
		end
		op1(SFD_OP_WREN);
		k = n_cmd;
		frame({SFD_OP_SEC_PROG, 16'h0000, r[7:0], r[15:8], 24'h0}, 5, 0);
		chk(n_cmd, k);
		frame({SFD_OP_SEC_PROG, 16'h0020, r[7:0], r[15:8], 24'h0}, 5, 0);
		chk(o_sec_index, 2'h2);
		op1(SFD_OP_WREN);
		op1(SFD_OP_WRDIS);
		chk(o_write_enable_latch, 1'b0);
		op1(SFD_OP_VOL_WREN);
		r = rnd();
		frame({SFD_OP_WRSR, r[23:0], 32'h0}, 4, 0);
		chk(o_cmd_volatile, 1'b1);
		chk(wdat, r[7:0]);
		k = n_cmd;
		frame({SFD_OP_WRSR, r[23:0], 32'h0}, 4, 0);
		chk(n_cmd, k);
		$display("test writes done");
		foreach (sro[i]) begin
			r = rnd();
			tick();
			{i_status_reg_first, i_status_reg_second,
				i_status_reg_third} = r[23:0];
			hdr({sro[i], 56'h0}, 1);
			get(r[23-8*i -: 8]);
			get(r[23-8*i -: 8]);
			host.xfer(8'h00, 3);
			host.close_f();
		end
		tick();
		i_array_busy = 1'b1;
		i_status_write_busy = 1'b1;
		op1(SFD_OP_WREN);
		chk(o_write_enable_latch, 1'b0);
		hdr({SFD_OP_RDSR1, 56'h0}, 1);
		get(i_status_reg_first);
		host.close_f();
		tick();
		i_array_busy = 1'b0;
		i_status_write_busy = 1'b0;
		$display("test status done");
		k = n_rst;
		op1(SFD_OP_RESET);
		op1(SFD_OP_RST_EN);
		op1(SFD_OP_RESET);
		chk(n_rst, k + 1);
		op1(SFD_OP_PWR_DOWN);
		chk(o_deep_power_down, 1'b1);
		op1(SFD_OP_WREN);
		chk(o_write_enable_latch, 1'b0);
		hdr({SFD_OP_RELEASE, 56'h0}, 4);
		get(8'hc3);
		get(8'hc3);
		host.close_f();
		chk(o_deep_power_down, 1'b0);
		$display("test power done");
		for (int i = 0; i < 2; i++) begin
			r = rnd();
			tick();
			k = fed;
			i_rd_valid = 1'b1;
			hdr({i ? SFD_OP_FAST : SFD_OP_READ, r[23:0], 32'h0}, 4 + i);
			chk(o_rd_ready, 1'b0);
			chk(o_cmd_addr, r[23:0]);
			for (int j = 0; j < 3; j++)
				get(dat(k + j));
			// Stop feeding right after a taken byte; no stale fill later
			@(posedge i_sys_clk iff o_rd_ready);
			#1 i_rd_valid = 1'b0;
			host.close_f();
		end
		for (int q = 0; q < 2; q++) begin
			tick();
			i_quad_enable_bit = q[0];
			hdr({SFD_OP_QUAD_OUT, 56'h0}, 6);
			chk(o_lane_oe_n, q ? 4'h0 : 4'hf);
			host.close_f();
		end
		r = rnd();
		hdr({SFD_OP_WRAP, 56'h0}, 4);
		for (int j = 0; j < 8; j++)
			host.xfer4(j == 6 ? {1'b0, r[2:0]} : 4'h0);
		host.close_f();
		chk(o_wrap_bits, r[2:0]);
		r = rnd();
		r[7:0] = 8'h20;
		hdr({SFD_OP_DUAL_IO, 56'h0}, 1);
		for (int j = 15; j >= 0; j--)
			host.xfer4({2'b00, r[2*j+1 -: 2]});
		host.close_f();
		chk(o_cmd_addr, r[31:8]);
		chk(o_cont_mode, 1'b1);
		hdr({8'hff, 8'hff, 48'h0}, 2);
		host.close_f();
		chk(o_cont_mode, 1'b0);
		k = n_cmd;
		frame(64'h0, 3, 0);
		chk(n_cmd, k);
		$display("test reads done");
		end_of_test();
	end

	// Some forty frames of a few bytes each need well under this span
	initial begin
		#400000;
		err_total++;
		end_of_test();
	end
endmodule
